/* rsc_top.sv */
// file: reset, warm reset and power-down state control of the peripheral
`timescale 1ns/10ps

// Operation
// RL1: micro i/o pins turn to inputs in power-on and warm reset and hold still in power-down.
// RL2: pld outputs are valid in warm reset and only after config load in power-on reset.
// RL3: in power-down pld outputs follow pld inputs while address inputs are blocked.
// RL4: address-out pins float in power-on and warm reset and are undefined in power-down.
// RL5: the data port floats in power-on reset, warm reset and power-down.
// RL6: peripheral i/o pins float in power-on reset, warm reset and power-down.
// RL7: power-on clears macrocells; warm reset and power-down leave them to user equations.
// RL8: code-space sram and peripheral-mode bits clear on every power-on and warm reset.
// RL9: both power management registers clear only at power-up.
// RL10: the mapping register loads its configured value on resets and holds in power-down.
// RL11: all other registers clear on both resets and hold in power-down.
module rsc_top (
    input  wire logic                        mclk,
    input  wire logic                        srst,
    input  wire logic                        warm_rst,
    input  wire logic                        power_down_state,
    input  wire logic [7:0]                  map_cfg,
    input  wire rsc_pkg::rsc_wr_s            wr,
    input  wire rsc_pkg::rsc_pin_s           mcu_io_drv,
    input  wire rsc_pkg::rsc_pin_s           addr_drv,
    input  wire rsc_pkg::rsc_pin_s           data_drv,
    input  wire rsc_pkg::rsc_pin_s           periph_drv,
    input  wire logic [rsc_pkg::PORT_W-1:0]  pld_in,
    input  wire logic [rsc_pkg::PORT_W-1:0]  addr_in,
    input  wire logic                        mc_clk_en,
    input  wire logic [rsc_pkg::MC_N-1:0]    macrocell_reset_equation,
    input  wire logic [rsc_pkg::MC_N-1:0]    macrocell_preset_equation,
    output rsc_pkg::rsc_pin_s                mcu_io_pin,
    output rsc_pkg::rsc_pin_s                addr_pin,
    output rsc_pkg::rsc_pin_s                data_pin,
    output rsc_pkg::rsc_pin_s                periph_pin,
    output logic [rsc_pkg::PORT_W-1:0]       pld_out,
    output logic                             pld_out_valid,
    output logic [rsc_pkg::MC_N-1:0]         macrocell_q,
    output logic [7:0]                       power_mgmt_mode_reg_a,
    output logic [7:0]                       power_mgmt_mode_reg_c,
    output logic [7:0]                       memory_mapping_reg,
    output logic [7:0]                       other_reg
);

    rsc_pkg::rsc_cond_e              cond;
    logic [rsc_pkg::CFG_CNT_W-1:0]   cfg_cnt_q, cfg_cnt_d;
    logic                            cfg_done_q, cfg_done_d;
    logic [7:0]                      pmmr_a_d, pmmr_c_d, map_d, other_d;
    rsc_pkg::rsc_pin_s               mcu_d, addr_d, data_d, periph_d;
    logic [rsc_pkg::PORT_W-1:0]      pld_d;
    logic                            pld_v_d;
    logic [rsc_pkg::PORT_W-1:0]      addr_gate;

    // condition decode: power-on beats warm reset beats power-down
    always_comb begin
        if (srst) begin
            cond = rsc_pkg::RSC_POR;
        end else if (warm_rst) begin
            cond = rsc_pkg::RSC_WARM;
        end else if (power_down_state) begin
            cond = rsc_pkg::RSC_PD;
        end else begin
            cond = rsc_pkg::RSC_RUN;
        end
    end

    // configuration load counter, restarted by power-on reset
    always_comb begin
        cfg_cnt_d  = cfg_cnt_q;
        cfg_done_d = cfg_done_q;
        if (srst) begin
            cfg_cnt_d  = '0;
            cfg_done_d = 1'b0;
        end else if (!cfg_done_q) begin
            cfg_cnt_d  = cfg_cnt_q + 1'b1;
            cfg_done_d = (cfg_cnt_q == rsc_pkg::CFG_CNT_W'(rsc_pkg::CFG_LOAD_CYC - 1));
        end
    end

    always_ff @(posedge mclk) begin
        cfg_cnt_q  <= cfg_cnt_d;
        cfg_done_q <= cfg_done_d;
    end

    // software register next values
    always_comb begin
        pmmr_a_d = power_mgmt_mode_reg_a;
        pmmr_c_d = power_mgmt_mode_reg_c;
        map_d    = memory_mapping_reg;
        other_d  = other_reg;
        unique case (cond)
            rsc_pkg::RSC_POR, rsc_pkg::RSC_WARM: begin
                // RL9 clear at power-up
                if (cond == rsc_pkg::RSC_POR) begin
                    pmmr_a_d = rsc_pkg::PMMR_RST;
                    pmmr_c_d = rsc_pkg::PMMR_RST;
                end
                // RL10 RL8 load configured map
                map_d   = map_cfg & ~rsc_pkg::MAP_CLR_MASK;
                // RL11 clear other registers
                other_d = rsc_pkg::OTHER_RST;
            end
            rsc_pkg::RSC_PD: begin
                // RL11 hold in power-down
                other_d = other_reg;
            end
            rsc_pkg::RSC_RUN: begin
                if (wr.pmmr_a_we) pmmr_a_d = wr.wdata;
                if (wr.pmmr_c_we) pmmr_c_d = wr.wdata;
                if (wr.map_we) map_d = wr.wdata;
                if (wr.other_we) other_d = wr.wdata;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        power_mgmt_mode_reg_a <= pmmr_a_d;
        power_mgmt_mode_reg_c <= pmmr_c_d;
        memory_mapping_reg    <= map_d;
        other_reg             <= other_d;
    end

    // RL3 address blocked from pld in power-down
    assign addr_gate = (cond == rsc_pkg::RSC_PD) ? '0 : addr_in;

    // pin and pld next values per condition
    always_comb begin
        mcu_d    = mcu_io_drv;
        addr_d   = addr_drv;
        data_d   = data_drv;
        periph_d = periph_drv;
        pld_d    = pld_in ^ addr_gate;
        pld_v_d  = 1'b1;
        unique case (cond)
            rsc_pkg::RSC_POR, rsc_pkg::RSC_WARM: begin
                // RL1 micro i/o to inputs
                mcu_d.oe    = '0;
                // RL4 address out floats
                addr_d.oe   = '0;
                // RL5 data port floats
                data_d.oe   = '0;
                // RL6 peripheral i/o floats
                periph_d.oe = '0;
                // RL2 pld valid after config load
                pld_v_d     = (cond == rsc_pkg::RSC_WARM) && cfg_done_q;
            end
            rsc_pkg::RSC_PD: begin
                // RL1 micro i/o frozen
                mcu_d       = mcu_io_pin;
                // RL5 RL6 data and peripheral float
                data_d.oe   = '0;
                periph_d.oe = '0;
                // RL4 address level undefined, held
                addr_d      = addr_pin;
            end
            rsc_pkg::RSC_RUN: begin
                pld_v_d = cfg_done_q;
            end
        endcase
        if (!pld_v_d) begin
            pld_d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        mcu_io_pin    <= mcu_d;
        addr_pin      <= addr_d;
        data_pin      <= data_d;
        periph_pin    <= periph_d;
        pld_out       <= pld_d;
        pld_out_valid <= pld_v_d;
    end

    // RL7 macrocell bank
    rsc_mcell u_mcell (
        .mclk   (mclk),
        .por    (srst),
        .clk_en (mc_clk_en),
        .d      (pld_in),
        .re_eq  (macrocell_reset_equation),
        .pr_eq  (macrocell_preset_equation),
        .q      (macrocell_q)
    );

    // RL5 data floats in any reset or power-down
    data_float_a: assert property (@(posedge mclk) //RL5
        (srst || warm_rst || power_down_state) |=> data_pin.oe == '0)
        else $error("data port driven in reset or power-down");

    // RL9 pmmr survives warm reset
    pmmr_keep_a: assert property (@(posedge mclk) disable iff (srst) //RL9
        warm_rst |=> $stable(power_mgmt_mode_reg_a) && $stable(power_mgmt_mode_reg_c))
        else $error("power management register changed by warm reset");

    // RL8 mapped bits cleared
    map_clear_a: assert property (@(posedge mclk) //RL8
        (srst || warm_rst) |=> memory_mapping_reg[rsc_pkg::MAP_SRCOD_BIT] == 1'b0
            && memory_mapping_reg[rsc_pkg::MAP_PERIPH_BIT] == 1'b0)
        else $error("mapping bits not cleared by reset");

    // RL7 power-on clears macrocells
    mc_por_a: assert property (@(posedge mclk) //RL7
        srst |=> macrocell_q == '0)
        else $error("macrocell not cleared by power-on");

    // RL1 micro pins frozen in power-down
    io_freeze_a: assert property (@(posedge mclk) disable iff (srst || warm_rst) //RL1
        power_down_state ##1 (power_down_state && !warm_rst && !srst) |=> $stable(mcu_io_pin))
        else $error("micro i/o changed in power-down");

    // RL2 pld not valid while power-on reset is held
    pld_load_a: assert property (@(posedge mclk) //RL2
        srst ##1 srst |=> !pld_out_valid)
        else $error("pld valid during power-on reset");

    // RL11 other registers cleared by resets
    other_clr_a: assert property (@(posedge mclk) //RL11
        (srst || warm_rst) |=> other_reg == '0)
        else $error("other register not cleared");

    // RL6 peripheral pins float
    periph_float_a: assert property (@(posedge mclk) //RL6
        (srst || warm_rst || power_down_state) |=> periph_pin.oe == '0)
        else $error("peripheral i/o driven in reset or power-down");

endmodule

/* rsc_pkg.sv */
// package: constants and carrier types of the reset state controller
package rsc_pkg;

    localparam int unsigned PORT_W = 8;
    localparam int unsigned MC_N   = 8;

    // condition that the block is in
    typedef enum logic [1:0] {
        RSC_RUN,
        RSC_POR,
        RSC_WARM,
        RSC_PD
    } rsc_cond_e;

    // reset values of the software registers and the macrocells
    localparam logic [7:0] PMMR_RST  = 8'h00;
    localparam logic [7:0] OTHER_RST = 8'h00;
    localparam logic [7:0] MC_RST    = 8'h00;
    // memory mapping register: code-space sram bit and peripheral-mode bit
    localparam int unsigned MAP_SRCOD_BIT  = 0;
    localparam int unsigned MAP_PERIPH_BIT = 7;
    localparam logic [7:0]  MAP_CLR_MASK   = 8'h81;

    // configuration load time after power-on, in cycles
    localparam int unsigned CFG_LOAD_CYC = 16;
    localparam int unsigned CFG_CNT_W    = 5;

    // pin group: value out and output enable, per bit
    typedef struct packed {
        logic [PORT_W-1:0] dout;
        logic [PORT_W-1:0] oe;
    } rsc_pin_s;

    // software register write
    typedef struct packed {
        logic       pmmr_a_we;
        logic       pmmr_c_we;
        logic       map_we;
        logic       other_we;
        logic [7:0] wdata;
    } rsc_wr_s;

endpackage

/* rsc_mcell.sv */
// file: output macrocell flip-flop bank with reset and preset equations
`timescale 1ns/10ps

module rsc_mcell (
    input  wire logic                      mclk,
    input  wire logic                      por,
    input  wire logic                      clk_en,
    input  wire logic [rsc_pkg::MC_N-1:0]  d,
    input  wire logic [rsc_pkg::MC_N-1:0]  re_eq,
    input  wire logic [rsc_pkg::MC_N-1:0]  pr_eq,
    output logic      [rsc_pkg::MC_N-1:0]  q
);

    logic [rsc_pkg::MC_N-1:0] q_d;

    // per-bit next state: power-on clears, else user equations, else data when clock-enabled, else hold
    genvar gi;
    generate
        for (gi = 0; gi < rsc_pkg::MC_N; gi++) begin : g_bit
            // RL7 macrocell reset priority
            always_comb begin
                if (por) begin
                    q_d[gi] = rsc_pkg::MC_RST[gi];
                end else if (re_eq[gi]) begin
                    q_d[gi] = 1'b0;
                end else if (pr_eq[gi]) begin
                    q_d[gi] = 1'b1;
                end else if (clk_en) begin
                    q_d[gi] = d[gi];
                end else begin
                    q_d[gi] = q[gi];
                end
            end
        end
    endgenerate

    // register the bank
    always_ff @(posedge mclk) begin
        q <= q_d;
    end

endmodule

/* rsc_host_model.sv */
// host model: drives power-on reset, warm reset and power-down levels
`timescale 1ns/10ps

module rsc_host_model (
    input  wire logic mclk,
    output logic      srst,
    output logic      warm_rst,
    output logic      power_down_state
);
    // power-on reset is asserted from time zero
    initial begin
        srst = 1'b1;
        warm_rst = 1'b0;
        power_down_state = 1'b0;
    end

    // hold one condition for n edges, changed just after an edge
    task automatic hold(input logic p, input logic w, input logic d, input int n);
        srst = p;
        warm_rst = w;
        power_down_state = d;
        repeat (n) @(posedge mclk);
        #1;
    endtask
endmodule

/* test_reset_state_control.sv */
// testbench: reset, warm reset and power-down states of the controller
`timescale 1ns/10ps

module test_reset_state_control;
    logic                      mclk, srst, warm_rst, power_down_state, mc_clk_en;
    logic [7:0]                map_cfg, pld_in, addr_in, re_eq, pr_eq, pld_out, mc_q;
    logic [7:0]                pm_a, pm_c, map_q, oth;
    logic                      pld_v;
    rsc_pkg::rsc_wr_s          wr;
    rsc_pkg::rsc_pin_s         mcu_d, adr_d, dat_d, per_d, mcu_p, adr_p, dat_p, per_p;
    int                        fails, n_compared;

    rsc_host_model rsc_host_model_i (.mclk(mclk), .srst(srst), .warm_rst(warm_rst),
        .power_down_state(power_down_state));

    rsc_top rsc_top_i (.mclk(mclk), .srst(srst), .warm_rst(warm_rst),
        .power_down_state(power_down_state), .map_cfg(map_cfg), .wr(wr),
        .mcu_io_drv(mcu_d), .addr_drv(adr_d), .data_drv(dat_d), .periph_drv(per_d),
        .pld_in(pld_in), .addr_in(addr_in), .mc_clk_en(mc_clk_en),
        .macrocell_reset_equation(re_eq), .macrocell_preset_equation(pr_eq),
        .mcu_io_pin(mcu_p), .addr_pin(adr_p), .data_pin(dat_p), .periph_pin(per_p),
        .pld_out(pld_out), .pld_out_valid(pld_v), .macrocell_q(mc_q),
        .power_mgmt_mode_reg_a(pm_a), .power_mgmt_mode_reg_c(pm_c),
        .memory_mapping_reg(map_q), .other_reg(oth));

    // 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // one-cycle register write strobe, sel 0..3 = pmmr a, pmmr c, map, other
    task automatic wr_reg(input int sel, input logic [7:0] v);
        wr = '{pmmr_a_we: sel == 0, pmmr_c_we: sel == 1, map_we: sel == 2,
               other_we: sel == 3, wdata: v};
        tick(1);
    endtask

    // pins float, pld is invalid, map loads the configured value and other registers clear while power-on reset is applied
    task automatic por_check(input logic [7:0] cfg);
        chk("mcu oe", 16'h0000, {8'h00, mcu_p.oe});
        chk("addr oe", 16'h0000, {8'h00, adr_p.oe});
        chk("data oe", 16'h0000, {8'h00, dat_p.oe});
        chk("periph oe", 16'h0000, {8'h00, per_p.oe});
        chk("pld valid", 16'h0000, {15'h0000, pld_v});
        chk("macrocell", 16'h0000, {8'h00, mc_q});
        chk("map", {8'h00, cfg & ~rsc_pkg::MAP_CLR_MASK}, {8'h00, map_q});
        chk("pmmr", 16'h0000, {pm_a, pm_c});
        chk("other", 16'h0000, {8'h00, oth});
    endtask

    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // watchdog, far beyond the expected run length
    initial begin
        #(2000 * 8);
        fails++;
        conclude();
    end

    initial begin
        fails = 0;
        n_compared = 0;
        map_cfg = 8'hff;
        wr = '0;
        mcu_d = '{dout: 8'h5a, oe: 8'hff};
        adr_d = '{dout: 8'h3c, oe: 8'hff};
        dat_d = '{dout: 8'h96, oe: 8'hff};
        per_d = '{dout: 8'hc3, oe: 8'h0f};
        pld_in = 8'h0f;
        addr_in = 8'h33;
        mc_clk_en = 1'b1;
        re_eq = 8'h00;
        pr_eq = 8'hff;
        rsc_host_model_i.hold(1'b1, 1'b0, 1'b0, 10);
        por_check(8'hff);
        rsc_host_model_i.hold(1'b0, 1'b0, 1'b0, 16);
        chk("pld valid early", 16'h0000, {15'h0000, pld_v});
        chk("mcu pin run", 16'h5aff, mcu_p);
        chk("addr pin run", 16'h3cff, adr_p);
        chk("data pin run", 16'h96ff, dat_p);
        chk("periph pin run", 16'hc30f, per_p);
        tick(1);
        chk("pld valid loaded", 16'h0001, {15'h0000, pld_v});
        chk("pld out", 16'h003c, {8'h00, pld_out});
        $display("test power_on done");
        wr_reg(0, 8'ha5);
        wr_reg(1, 8'h5a);
        wr_reg(2, 8'hc3);
        wr_reg(3, 8'h99);
        wr = '0;
        re_eq = 8'h0f;
        pr_eq = 8'hf0;
        tick(1);
        chk("regs run", 16'hc399, {map_q, oth});
        wr = '{pmmr_a_we: 1'b0, pmmr_c_we: 1'b0, map_we: 1'b0, other_we: 1'b1, wdata: 8'h11};
        rsc_host_model_i.hold(1'b0, 1'b1, 1'b0, 1);
        wr = '0;
        chk("warm mcu oe", 16'h0000, {8'h00, mcu_p.oe});
        chk("warm addr oe", 16'h0000, {8'h00, adr_p.oe});
        chk("warm data oe", 16'h0000, {8'h00, dat_p.oe});
        chk("warm periph oe", 16'h0000, {8'h00, per_p.oe});
        chk("warm pld", 16'h013c, {7'h00, pld_v, pld_out});
        chk("warm macrocell", 16'h00f0, {8'h00, mc_q});
        chk("warm map", 16'h007e, {8'h00, map_q});
        chk("warm pmmr", 16'ha55a, {pm_a, pm_c});
        chk("warm other", 16'h0000, {8'h00, oth});
        rsc_host_model_i.hold(1'b0, 1'b0, 1'b0, 1);
        chk("mcu pin after warm", 16'h5aff, mcu_p);
        $display("test warm_reset done");
        wr_reg(2, 8'hc3);
        wr_reg(3, 8'h77);
        wr = '{pmmr_a_we: 1'b0, pmmr_c_we: 1'b0, map_we: 1'b1, other_we: 1'b1, wdata: 8'h00};
        mcu_d = '{dout: 8'h12, oe: 8'h0f};
        rsc_host_model_i.hold(1'b0, 1'b0, 1'b1, 3);
        wr = '0;
        chk("pd mcu pin", 16'h5aff, mcu_p);
        chk("pd data oe", 16'h0000, {8'h00, dat_p.oe});
        chk("pd periph oe", 16'h0000, {8'h00, per_p.oe});
        chk("pd pld out", 16'h000f, {8'h00, pld_out});
        chk("pd macrocell", 16'h00f0, {8'h00, mc_q});
        chk("pd pmmr", 16'ha55a, {pm_a, pm_c});
        chk("pd map other", 16'hc377, {map_q, oth});
        re_eq = 8'h00;
        pr_eq = 8'h00;
        tick(1);
        chk("pd macrocell data", 16'h000f, {8'h00, mc_q});
        mc_clk_en = 1'b0;
        pld_in = 8'ha0;
        tick(1);
        chk("pd macrocell hold", 16'h000f, {8'h00, mc_q});
        $display("test power_down done");
        map_cfg = 8'h3c;
        rsc_host_model_i.hold(1'b1, 1'b0, 1'b0, 2);
        por_check(8'h3c);
        $display("test second_power_on done");
        conclude();
    end
endmodule
